/* logic/bbc_backup_ctrl.v */
/*
 * Control and status register bank of a battery backed domain, APB slave.
 * Assumes the crystal swing, battery sense and unlock inputs are synchronous
 * to sys_clk_i; the real oscillator and counter sit outside.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "bbc_defs.vh"

module bbc_backup_ctrl #(
  parameter FAIL_SWINGS = `BBC_FAIL_SWINGS
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire clk_en_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire ccp_unlock_i,
  input wire osc_swing_i,
  input wire osc_stable_i,
  input wire battery_present_i,
  input wire battery_brownout_i,
  input wire on_battery_i,
  input wire battery_inserted_i,
  output reg high_drive_strength_o,
  output reg osc_output_select_o,
  output reg crystal_osc_enable_o,
  output reg osc_failure_detect_enable_o,
  output reg domain_reset_o,
  output reg power_switch_open_o
);

  //////////////////////////////////////////////////////////////////////////
  reg access_gate_enable;
  reg [7:0] retained_byte_0;
  reg [7:0] retained_byte_1;
  reg battery_absent_flag;
  reg osc_ready_flag;
  reg osc_failure_flag;
  reg battery_brownout_flag;
  reg battery_poweron_flag;
  reg swing_prev;
  reg [6:0] idle_count;
  reg startup_done;
  reg [7:0] next_rdata;
  reg next_access_gate_enable;
  reg next_high_drive;
  reg next_output_select;
  reg next_osc_enable;
  reg next_fail_det_enable;
  reg next_ready_flag;
  reg next_failure_flag;
  reg [6:0] next_idle_count;
  reg next_absent_flag;
  reg next_brownout_flag;
  reg next_poweron_flag;
  reg next_switch_open;

  //////////////////////////////////////////////////////////////////////////
  // Exact word match; the byte lanes above the low one are unused
  function addr_hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Write-one-to-clear request for one status bit
  function w1c_hit;
    input strobe;
    input [7:0] data;
    input integer pos;
    begin
      w1c_hit = strobe & data[pos];
    end
  endfunction

  wire setup = psel_i & ~penable_i;
  // Writes land at the access edge, where the master sees pready high
  wire access = psel_i & penable_i & pready_o;
  wire wr = access & pwrite_i & pstrb_i[0];
  wire rd = setup & ~pwrite_i;
  wire hit_ctl = addr_hit(paddr_i, `BBC_ADDR_CONTROL);
  wire hit_sts = addr_hit(paddr_i, `BBC_ADDR_STATUS);
  wire hit_r0 = addr_hit(paddr_i, `BBC_ADDR_RETAIN0);
  wire hit_r1 = addr_hit(paddr_i, `BBC_ADDR_RETAIN1);
  wire mapped = hit_ctl | hit_sts | hit_r0 | hit_r1;
  wire [7:0] wd = pwdata_i[7:0];
  // Gated writes vanish entirely; ungated flag clears still pass
  wire gated_wr = wr & access_gate_enable;
  wire ctl_wr = wr & hit_ctl;
  wire ctl_gated_wr = gated_wr & hit_ctl;
  wire sts_wr = wr & hit_sts;
  wire sts_gated_wr = gated_wr & hit_sts;
  wire enable_write = ctl_gated_wr &
    (wd[`BBC_CTL_OSC_EN] | wd[`BBC_CTL_FAIL_DET_EN]);
  // Domain reset: unlocked write of one, not combined with enables
  wire dom_rst = ctl_gated_wr & wd[`BBC_CTL_DOMAIN_RESET] &
    ccp_unlock_i & ~enable_write;
  wire swing_edge = osc_swing_i ^ swing_prev;
  wire fail_detect = osc_failure_detect_enable_o & crystal_osc_enable_o &
    (idle_count == FAIL_SWINGS - 7'd1) & ~swing_edge;

  //////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
      if (rd)
        prdata_o <= {24'h000000, next_rdata};
    end
  end

  // Control image; with the gate shut only the gate bit shows
  function [7:0] pack_control;
    input gate;
    input [3:0] config_bits;
    begin
      pack_control = 8'h00;
      pack_control[`BBC_CTL_ACCESS_GATE] = gate;
      if (gate) begin
        pack_control[`BBC_CTL_HIGH_DRIVE] = config_bits[3];
        pack_control[`BBC_CTL_OUT_SEL] = config_bits[2];
        pack_control[`BBC_CTL_OSC_EN] = config_bits[1];
        pack_control[`BBC_CTL_FAIL_DET_EN] = config_bits[0];
      end
    end
  endfunction

  // Status image; supervision flags stay visible with the gate shut
  function [7:0] pack_status;
    input gate;
    input [4:0] flags;
    begin
      pack_status = 8'h00;
      pack_status[`BBC_STS_BAT_ABSENT] = flags[4];
      pack_status[`BBC_STS_OSC_READY] = flags[3] & gate;
      pack_status[`BBC_STS_OSC_FAIL] = flags[2] & gate;
      pack_status[`BBC_STS_BROWNOUT] = flags[1];
      pack_status[`BBC_STS_POWERON] = flags[0];
    end
  endfunction

  always @* begin
    next_rdata = 8'h00;
    if (hit_ctl) begin
      next_rdata = pack_control(access_gate_enable, {high_drive_strength_o,
        osc_output_select_o, crystal_osc_enable_o, osc_failure_detect_enable_o});
    end else if (hit_sts) begin
      next_rdata = pack_status(access_gate_enable, {battery_absent_flag,
        osc_ready_flag, osc_failure_flag, battery_brownout_flag,
        battery_poweron_flag});
    end else if (hit_r0 && access_gate_enable) begin
      next_rdata = retained_byte_0;
    end else if (hit_r1 && access_gate_enable) begin
      next_rdata = retained_byte_1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Access gate: any control write may open it, only device reset shuts it
  always @* begin
    next_access_gate_enable = access_gate_enable;
    if (ctl_wr && wd[`BBC_CTL_ACCESS_GATE])
      next_access_gate_enable = 1'b1;
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      access_gate_enable <= 1'b0;
    else if (clk_en_i)
      access_gate_enable <= next_access_gate_enable;
  end

  // Domain configuration; the enables are set-only until a domain reset
  always @* begin
    next_high_drive = high_drive_strength_o;
    next_output_select = osc_output_select_o;
    next_osc_enable = crystal_osc_enable_o;
    next_fail_det_enable = osc_failure_detect_enable_o;
    next_ready_flag = osc_ready_flag;
    if (dom_rst) begin
      next_high_drive = 1'b0;
      next_output_select = 1'b0;
      next_osc_enable = 1'b0;
      next_fail_det_enable = 1'b0;
      next_ready_flag = 1'b0;
    end else begin
      if (ctl_gated_wr) begin
        next_high_drive = wd[`BBC_CTL_HIGH_DRIVE];
        // Select frozen while running: a swap would glitch the counter clock
        if (!crystal_osc_enable_o)
          next_output_select = wd[`BBC_CTL_OUT_SEL];
        if (wd[`BBC_CTL_OSC_EN])
          next_osc_enable = 1'b1;
        if (wd[`BBC_CTL_FAIL_DET_EN])
          next_fail_det_enable = 1'b1;
      end
      if (crystal_osc_enable_o && osc_stable_i)
        next_ready_flag = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_drive_strength_o <= 1'b0;
      osc_output_select_o <= 1'b0;
      crystal_osc_enable_o <= 1'b0;
      osc_failure_detect_enable_o <= 1'b0;
      osc_ready_flag <= 1'b0;
      domain_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      high_drive_strength_o <= next_high_drive;
      osc_output_select_o <= next_output_select;
      crystal_osc_enable_o <= next_osc_enable;
      osc_failure_detect_enable_o <= next_fail_det_enable;
      osc_ready_flag <= next_ready_flag;
      domain_reset_o <= dom_rst;
    end
  end

  // Missed-swing counter: restarts on every crystal edge
  always @* begin
    next_idle_count = idle_count;
    if (dom_rst || swing_edge || !osc_failure_detect_enable_o)
      next_idle_count = 7'h00;
    else if (idle_count != FAIL_SWINGS - 7'd1)
      next_idle_count = idle_count + 7'd1;
  end

  // A stop seen in the clearing cycle wins, so no failure goes unreported
  always @* begin
    next_failure_flag = osc_failure_flag;
    if (dom_rst)
      next_failure_flag = 1'b0;
    else if (fail_detect)
      next_failure_flag = 1'b1;
    else if (w1c_hit(sts_gated_wr, wd, `BBC_STS_OSC_FAIL))
      next_failure_flag = 1'b0;
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swing_prev <= 1'b0;
      idle_count <= 7'h00;
      osc_failure_flag <= 1'b0;
    end else if (clk_en_i) begin
      swing_prev <= osc_swing_i;
      idle_count <= next_idle_count;
      osc_failure_flag <= next_failure_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Supervision flags; hardware set wins over write-one clear
  always @* begin
    next_absent_flag = battery_absent_flag;
    next_brownout_flag = battery_brownout_flag;
    next_poweron_flag = battery_poweron_flag;
    next_switch_open = power_switch_open_o;
    // Battery sense is looked at once, in the first enabled cycle
    if (!startup_done && !battery_present_i)
      next_absent_flag = 1'b1;
    else if (w1c_hit(sts_wr, wd, `BBC_STS_BAT_ABSENT))
      next_absent_flag = 1'b0;
    if (on_battery_i && battery_brownout_i)
      next_brownout_flag = 1'b1;
    else if (w1c_hit(sts_wr, wd, `BBC_STS_BROWNOUT))
      next_brownout_flag = 1'b0;
    // Later insertions leave the flag alone until the next start-up
    if (!startup_done && battery_inserted_i) begin
      next_poweron_flag = 1'b1;
      next_switch_open = 1'b1;
    end else if (w1c_hit(sts_wr, wd, `BBC_STS_POWERON)) begin
      next_poweron_flag = 1'b0;
    end
    // Switch stays open to spare the battery until the oscillator is set up
    if (ctl_gated_wr && wd[`BBC_CTL_OSC_EN])
      next_switch_open = 1'b0;
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      startup_done <= 1'b0;
      battery_absent_flag <= 1'b0;
      battery_brownout_flag <= 1'b0;
      battery_poweron_flag <= 1'b0;
      power_switch_open_o <= 1'b0;
    end else if (clk_en_i) begin
      startup_done <= 1'b1;
      battery_absent_flag <= next_absent_flag;
      battery_brownout_flag <= next_brownout_flag;
      battery_poweron_flag <= next_poweron_flag;
      power_switch_open_o <= next_switch_open;
    end
  end

  // Retained bytes: no domain reset, kept across power loss
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      retained_byte_0 <= `BBC_RETAIN_RESET;
      retained_byte_1 <= `BBC_RETAIN_RESET;
    end else if (clk_en_i && gated_wr) begin
      if (hit_r0)
        retained_byte_0 <= wd;
      if (hit_r1)
        retained_byte_1 <= wd;
    end
  end

endmodule // bbc_backup_ctrl

/* logic/bbc_defs.vh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * battery backup control block. Assumes inclusion by bare name.
 */
`ifndef BBC_DEFS_VH
`define BBC_DEFS_VH

`define BBC_IDX_CONTROL 2'h0
`define BBC_IDX_STATUS 2'h1
`define BBC_IDX_RETAIN0 2'h2
`define BBC_IDX_RETAIN1 2'h3
`define BBC_ADDR_CONTROL 12'h000
`define BBC_ADDR_STATUS 12'h004
`define BBC_ADDR_RETAIN0 12'h008
`define BBC_ADDR_RETAIN1 12'h00c

`define BBC_CTL_DOMAIN_RESET 0
`define BBC_CTL_ACCESS_GATE 1
`define BBC_CTL_FAIL_DET_EN 2
`define BBC_CTL_OSC_EN 3
`define BBC_CTL_OUT_SEL 4
`define BBC_CTL_HIGH_DRIVE 5

`define BBC_STS_POWERON 0
`define BBC_STS_BROWNOUT 1
`define BBC_STS_OSC_FAIL 2
`define BBC_STS_OSC_READY 3
`define BBC_STS_BAT_ABSENT 7

`define BBC_CONTROL_RESET 8'h00
`define BBC_RETAIN_RESET 8'h00
`define BBC_FAIL_SWINGS 7'h40

`endif

/* verif/bbc_checker.sv */
/* Port checker of the backup control bank.
   Assumes one clock and an active low reset. */
`timescale 1ns/1ns
module bbc_checker (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire clk_en_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire ccp_unlock_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire high_drive_strength_o,
  input wire osc_output_select_o,
  input wire crystal_osc_enable_o,
  input wire osc_failure_detect_enable_o,
  input wire domain_reset_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire setup = psel_i && !penable_i && clk_en_i;
  // Writes take effect at the access edge, with pready high
  wire ctl_wr = psel_i && penable_i && pready_o && clk_en_i && pwrite_i &&
    paddr_i == 12'h000;
  wire dr = domain_reset_o;
  answer_next_a: assert property (setup |=> pready_o) else $error("no answer");
  err_in_access_a: assert property (pslverr_o |-> pready_o && penable_i) else $error("stray error");
  pulse_single_a: assert property (dr |=> !dr) else $error("long pulse");
  pulse_cause_a: assert property (
    $rose(dr) |-> $past(ctl_wr && ccp_unlock_i && pwdata_i[0])) else $error("reset without unlock");
  pulse_block_a: assert property (
    $rose(dr) |-> $past(!pwdata_i[3] && !pwdata_i[2])) else $error("reset not blocked");
  reset_clears_a: assert property (
    dr |=> !(high_drive_strength_o || osc_output_select_o || crystal_osc_enable_o
    || osc_failure_detect_enable_o)) else $error("bits kept");
  osc_sticky_a: assert property (
    $fell(crystal_osc_enable_o) |-> dr || $past(dr)) else $error("osc dropped");
  mon_sticky_a: assert property (
    $fell(osc_failure_detect_enable_o) |-> dr || $past(dr)) else $error("monitor dropped");
  sel_frozen_a: assert property (
    $changed(osc_output_select_o) |-> !$past(crystal_osc_enable_o) || dr || $past(dr))
    else $error("select moved");
  drive_cause_a: assert property (
    $rose(high_drive_strength_o) |-> $past(ctl_wr && pwdata_i[5])) else $error("drive rose");
endmodule // bbc_checker
////////////////////////////////////////////////////////////////////////////////
bind bbc_backup_ctrl bbc_checker bbc_checker_i (.sys_clk_i, .rst_b_i, .clk_en_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .ccp_unlock_i, .pready_o, .pslverr_o,
  .high_drive_strength_o, .osc_output_select_o, .crystal_osc_enable_o,
  .osc_failure_detect_enable_o, .domain_reset_o);

/* verif/bbc_backup_ctrl_test.sv */
/* Self-checking bench of the backup control bank.
   Assumes the answer comes in the access phase. */
`timescale 1ns/1ns
`include "bbc_defs.vh"
module bbc_backup_ctrl_test;
  reg sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg ccp = 1'b0, swing_on = 1'b1, swing = 1'b0, stable = 1'b0, bo = 1'b0, onbat = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, hd, sel, en, fd, dr, sw;
  wire [31:0] outs = {28'h0, hd, sel, en, fd};
  integer fail_count = 0, compares = 0, pulses = 0;
  localparam [11:0] a_c = `BBC_ADDR_CONTROL, a_s = `BBC_ADDR_STATUS;
  bbc_backup_ctrl bbc_backup_ctrl_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ccp_unlock_i(ccp), .osc_swing_i(swing), .osc_stable_i(stable), .battery_present_i(1'b0),
    .battery_brownout_i(bo), .on_battery_i(onbat), .battery_inserted_i(1'b1),
    .high_drive_strength_o(hd), .osc_output_select_o(sel), .crystal_osc_enable_o(en),
    .osc_failure_detect_enable_o(fd), .domain_reset_o(dr), .power_switch_open_o(sw));
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (swing_on) swing <= ~swing;
  always @(negedge sys_clk) if (dr === 1'b1) pulses = pulses + 1;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [255:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error %0s: expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 20) begin
        fail_count = fail_count + 1;
        $display("Error pready: expected 1 seen %b", pready);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e, input [255:0] nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  task t_start;
    begin
      rdc(a_s, 32'h81, "start flags");
      chk("switch", 32'h1, {31'h0, sw});
      apb(1'b1, a_c, 32'h3c);
      chk("gated ctl", 32'h0, outs);
      apb(1'b1, `BBC_ADDR_RETAIN0, 32'h77);
      rdc(`BBC_ADDR_RETAIN0, 32'h0, "gated byte");
      apb(1'b1, 12'h010, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, a_s, 32'h83);
      rdc(a_s, 32'h0, "flags clear");
      $display("start test done");
    end
  endtask
  task t_gate;
    begin
      apb(1'b1, a_c, 32'hc2);
      apb(1'b1, a_c, 32'h0);
      rdc(a_c, 32'h02, "gate");
      apb(1'b1, `BBC_ADDR_RETAIN0, 32'ha5);
      apb(1'b1, `BBC_ADDR_RETAIN1, 32'h5a);
      rdc(`BBC_ADDR_RETAIN0, 32'ha5, "byte0");
      rdc(`BBC_ADDR_RETAIN1, 32'h5a, "byte1");
      $display("gate test done");
    end
  endtask
  task t_osc;
    begin
      apb(1'b1, a_c, 32'h12);
      chk("select", 32'h4, outs);
      apb(1'b1, a_c, 32'h3e);
      chk("switch off", 32'h0, {31'h0, sw});
      stable <= 1'b1;
      apb(1'b1, a_c, 32'h22);
      chk("sticky", 32'hf, outs);
      rdc(a_s, 32'h08, "ready");
      swing_on <= 1'b0;
      repeat (50) @(posedge sys_clk);
      rdc(a_s, 32'h08, "early fail");
      repeat (20) @(posedge sys_clk);
      rdc(a_s, 32'h0c, "fail");
      swing_on <= 1'b1;
      apb(1'b1, a_s, 32'h04);
      rdc(a_s, 32'h08, "fail clear");
      $display("osc test done");
    end
  endtask
  task t_reset;
    begin
      onbat <= 1'b1;
      bo <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bo <= 1'b0;
      onbat <= 1'b0;
      rdc(a_s, 32'h0a, "brownout");
      apb(1'b1, a_s, 32'h02);
      apb(1'b1, a_c, 32'h01);
      chk("locked", 32'h0, pulses);
      ccp <= 1'b1;
      apb(1'b1, a_c, 32'h05);
      chk("blocked", 32'h0, pulses);
      apb(1'b1, a_c, 32'h01);
      chk("pulses", 32'h1, pulses);
      chk("cleared", 32'h0, outs);
      rdc(a_c, 32'h02, "ctl after");
      rdc(a_s, 32'h0, "sts after");
      $display("reset test done");
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_start;
    t_gate;
    t_osc;
    t_reset;
    give_verdict;
  end
  initial begin
    #500000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule // bbc_backup_ctrl_test
